// [dma_trig_pkg.sv]
package dma_trig_pkg;
  // ----------------------------------------------------------------
  // register map (word indices on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] reg_request_select_off = 4'h0;
  localparam logic [3:0] reg_start_addr_high_off = 4'h1;
  localparam logic [3:0] reg_start_addr_low_off = 4'h2;
  localparam logic [3:0] reg_channel_ctrl_off = 4'h3;
  localparam logic [3:0] reg_channel_status_off = 4'h4;
  localparam logic [3:0] reg_done_count_off = 4'h5;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int manual_trigger_bit = 15;
  localparam int channel_on_bit = 0;
  localparam logic [7:0] request_select_reset = 8'h00;
  localparam logic [7:0] start_addr_high_reset = 8'h00;
  localparam logic [15:0] start_addr_low_reset = 16'h0000;
  localparam logic [15:0] done_count_reset = 16'h0000;
  // ----------------------------------------------------------------
  // request sources and buffer
  // ----------------------------------------------------------------
  localparam int num_request_lines = 256;
  localparam int buffer_depth = 2;
  // number of system cycles the channel stays in st_busy before each push into the buffer
  localparam logic [3:0] transfer_cycles = 4'h2;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_busy = 3'b010,
    st_push = 3'b100
  } chan_state_t;
endpackage : dma_trig_pkg

// [dma_req_buffer.sv]
module dma_req_buffer
  import dma_trig_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  input wire logic [23:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [23:0] out_data_out,
  input wire logic out_ready_in
);
  // ----------------------------------------------------------------
  // two-entry buffer, flop storage indexed by pointers
  // ----------------------------------------------------------------
  logic [23:0] mem_q [buffer_depth];
  logic [23:0] mem_d [buffer_depth];
  logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [1:0] count_q, count_d;
  logic push, pop;

  always_comb
  begin
    push = in_valid_in && (count_q != 2'd2);
    pop = out_ready_in && (count_q != 2'd0);
    wr_ptr_d = wr_ptr_q ^ push;
    rd_ptr_d = rd_ptr_q ^ pop;
    count_d = 2'(count_q + {1'b0, push} - {1'b0, pop});
  end

  for (genvar i = 0; i < buffer_depth; i++)
  begin : g_entry
    always_comb
    begin
      mem_d[i] = mem_q[i];
      if (push && (wr_ptr_q == 1'(i)))
        mem_d[i] = in_data_in;
    end
    always_ff @(posedge core_clk_in)
    begin
      mem_q[i] <= mem_d[i];
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'd0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  assign in_ready_out = (count_q != 2'd2);
  assign out_valid_out = (count_q != 2'd0);
  assign out_data_out = mem_q[rd_ptr_q];
endmodule : dma_req_buffer

// [dma_channel_trigger.sv]
module dma_channel_trigger
  import dma_trig_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [15:0] reg_rdata_out,
  input wire logic [num_request_lines-1:0] periph_req_in,
  input wire logic [num_request_lines-1:0] periph_mapped_in,
  output logic xfer_valid_out,
  output logic [23:0] xfer_addr_out,
  input wire logic xfer_ready_in
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic manual_q, manual_d;
  logic [7:0] sel_q, sel_d;
  logic [7:0] addr_high_q, addr_high_d;
  logic [15:0] addr_low_q, addr_low_d;
  logic on_q, on_d;
  logic [15:0] done_q, done_d;
  logic [15:0] rdata_q, rdata_d;
  chan_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic forced_q, forced_d;
  logic valid_q, valid_d;
  logic [23:0] oaddr_q, oaddr_d;
  logic buf_ready, buf_valid;
  logic [23:0] buf_data;
  logic wr_sel, wr_high, wr_low, wr_ctrl;
  logic periph_hit, req_pend_q, req_pend_d;
  logic start, finish;

  // ----------------------------------------------------------------
  // register writes and transfer sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    wr_sel = reg_write_in && (reg_addr_in == reg_request_select_off);
    wr_high = reg_write_in && (reg_addr_in == reg_start_addr_high_off);
    wr_low = reg_write_in && (reg_addr_in == reg_start_addr_low_off);
    wr_ctrl = reg_write_in && (reg_addr_in == reg_channel_ctrl_off);
    // an unmapped code never hits, even if the line wiggles
    periph_hit = periph_req_in[sel_q] && periph_mapped_in[sel_q];
    // a peripheral event seen while busy is remembered, not lost
    req_pend_d = req_pend_q || periph_hit;
    on_d = wr_ctrl ? reg_wdata_in[channel_on_bit] : on_q;
    sel_d = wr_sel ? reg_wdata_in[7:0] : sel_q;
    addr_high_d = wr_high ? reg_wdata_in[7:0] : addr_high_q;
    addr_low_d = wr_low ? reg_wdata_in : addr_low_q;
    manual_d = manual_q;
    state_d = state_q;
    cnt_d = cnt_q;
    forced_d = forced_q;
    done_d = done_q;
    start = 1'b0;
    finish = 1'b0;
    case (state_q)
      st_idle:
      begin
        // manual trigger takes priority over peripheral requests
        if (on_q && (manual_q || req_pend_q))
        begin
          start = 1'b1;
          forced_d = manual_q;
          if (!manual_q)
            req_pend_d = periph_hit;
          cnt_d = transfer_cycles;
          state_d = st_busy;
        end
      end
      st_busy:
      begin
        cnt_d = 4'(cnt_q - 4'h1);
        if (cnt_q == 4'h1)
          state_d = st_push;
      end
      st_push:
      begin
        // hold here until the buffer accepts, so a stall loses nothing
        if (buf_ready)
        begin
          finish = 1'b1;
          done_d = 16'(done_q + 16'h0001);
          state_d = st_idle;
        end
      end
      default:
      begin
        state_d = st_idle;
      end
    endcase
    if (finish && forced_q)
      manual_d = 1'b0;
    // a new software set in the finishing cycle wins over the hardware clear
    if (wr_sel && reg_wdata_in[manual_trigger_bit])
      manual_d = 1'b1;
    if (!on_q)
    begin
      manual_d = 1'b0;
      req_pend_d = 1'b0;
    end
    if (start)
      forced_d = manual_q;
  end

  // ----------------------------------------------------------------
  // read mux, one cycle latency
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = 16'h0000;
    if (reg_read_in)
    begin
      case (reg_addr_in)
        reg_request_select_off: rdata_d = {manual_q, 7'h00, sel_q};
        reg_start_addr_high_off: rdata_d = {8'h00, addr_high_q};
        reg_start_addr_low_off: rdata_d = addr_low_q;
        reg_channel_ctrl_off: rdata_d = {15'h0000, on_q};
        reg_channel_status_off: rdata_d = {13'h0000, state_q};
        reg_done_count_off: rdata_d = done_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
      rdata_q <= 16'h0000;
    else
      rdata_q <= rdata_d;
  end

  // ----------------------------------------------------------------
  // output stage: one registered word in front of the memory bus
  // ----------------------------------------------------------------
  always_comb
  begin
    valid_d = valid_q;
    oaddr_d = oaddr_q;
    // reload only when empty or draining, so a held word never changes under a stall
    if (!valid_q || xfer_ready_in)
    begin
      valid_d = buf_valid;
      // an empty buffer entry is never copied, so the address stays defined
      if (buf_valid)
        oaddr_d = buf_data;
    end
  end

  dma_req_buffer u_buf (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(state_q == st_push),
    .in_data_in({addr_high_q, addr_low_q}),
    .in_ready_out(buf_ready),
    .out_valid_out(buf_valid),
    .out_data_out(buf_data),
    .out_ready_in(!valid_q || xfer_ready_in)
  );

  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      valid_q <= 1'b0;
      oaddr_q <= 24'h00_0000;
    end
    else
    begin
      valid_q <= valid_d;
      oaddr_q <= oaddr_d;
    end
  end

  // ----------------------------------------------------------------
  // channel state registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      manual_q <= 1'b0;
      sel_q <= request_select_reset;
      addr_high_q <= start_addr_high_reset;
      addr_low_q <= start_addr_low_reset;
      on_q <= 1'b0;
      done_q <= done_count_reset;
      state_q <= st_idle;
      cnt_q <= 4'h0;
      forced_q <= 1'b0;
      req_pend_q <= 1'b0;
    end
    else
    begin
      manual_q <= manual_d;
      sel_q <= sel_d;
      addr_high_q <= addr_high_d;
      addr_low_q <= addr_low_d;
      on_q <= on_d;
      done_q <= done_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      forced_q <= forced_d;
      req_pend_q <= req_pend_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign xfer_valid_out = valid_q;
  assign xfer_addr_out = oaddr_q;
endmodule : dma_channel_trigger

// [dma_channel_trigger_assertions.sv]
module dma_channel_trigger_assertions
  import dma_trig_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic xfer_valid_out,
  input wire logic [23:0] xfer_addr_out,
  input wire logic xfer_ready_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // shadow of channel_on, kept from register writes
  // ----
  logic on_q;
  logic on_d;
  logic rd_hi;
  assign rd_hi = reg_read_in && reg_addr_in == reg_start_addr_high_off;
  always_comb
  begin
    on_d = on_q;
    if (reg_write_in && reg_addr_in == reg_channel_ctrl_off)
      on_d = reg_wdata_in[channel_on_bit];
    if (!resetn_in)
      on_d = 1'b0;
  end
  always_ff @(posedge core_clk_in)
    on_q <= on_d;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 16'h0000)
    else $error("read data not zero outside read");
  a_reset_quiet: assert property ($rose(resetn_in) |-> !xfer_valid_out && reg_rdata_out == 16'h0000)
    else $error("outputs not quiet after reset");
  a_high_top_zero: assert property (rd_hi |=> reg_rdata_out[15:8] == 8'h00)
    else $error("start high upper byte not zero");
  a_high_round_trip: assert property (
    reg_write_in && reg_addr_in == reg_start_addr_high_off ##1 rd_hi
    |=> reg_rdata_out[7:0] == $past(reg_wdata_in[7:0], 2)) else $error("start high lost data");
  a_unmapped_zero: assert property (
    reg_read_in && reg_addr_in > reg_done_count_off |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_off_no_trigger: assert property (
    !on_q && !$past(on_q) && reg_read_in && reg_addr_in == reg_request_select_off
    |=> !reg_rdata_out[manual_trigger_bit]) else $error("trigger set while channel off");
  a_valid_holds: assert property (xfer_valid_out && !xfer_ready_in
    |=> xfer_valid_out && $stable(xfer_addr_out)) else $error("transfer dropped while stalled");
  a_manual_starts: assert property (
    on_q && !xfer_valid_out && reg_write_in && reg_addr_in == reg_request_select_off
    && reg_wdata_in[manual_trigger_bit] |-> ##[1:8] (xfer_valid_out || !on_q))
    else $error("manual trigger started nothing");
  c_taken: cover property (xfer_valid_out && xfer_ready_in);
  c_stall: cover property (xfer_valid_out && !xfer_ready_in ##1 xfer_ready_in);
  c_round: cover property (reg_write_in ##1 rd_hi);
endmodule : dma_channel_trigger_assertions

bind dma_channel_trigger dma_channel_trigger_assertions chk (
  .core_clk_in(core_clk_in),
  .resetn_in(resetn_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out),
  .xfer_valid_out(xfer_valid_out),
  .xfer_addr_out(xfer_addr_out),
  .xfer_ready_in(xfer_ready_in)
);

// [dma_far_model.sv]
module dma_far_model
  import dma_trig_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic stall_in,
  input wire logic [7:0] fire_code_in,
  input wire logic fire_in,
  input wire logic xfer_valid_in,
  input wire logic [23:0] xfer_addr_in,
  output logic [num_request_lines-1:0] periph_req_out,
  output logic [num_request_lines-1:0] periph_mapped_out,
  output logic xfer_ready_out,
  output logic [23:0] last_addr_out,
  output int taken_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // request sources and memory bus
  // ----
  // only three codes carry a peripheral; lines of the rest still toggle
  assign periph_mapped_out = (256'h1 << 8'h00) | (256'h1 << 8'h0a) | (256'h1 << 8'h5b);
  assign periph_req_out = fire_in ? (256'h1 << fire_code_in) : '0;
  assign xfer_ready_out = !stall_in;
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      last_addr_out <= 24'h00_0000;
      taken_out <= 0;
    end
    else if (xfer_valid_in && xfer_ready_out)
    begin
      last_addr_out <= xfer_addr_in;
      taken_out <= taken_out + 1;
    end
  end
endmodule : dma_far_model

// [test_dma_channel_trigger.sv]
module test_dma_channel_trigger
  import dma_trig_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic stall = 1'b0;
  logic fire = 1'b0;
  logic [7:0] code = 8'h00;
  logic [15:0] rdata;
  logic [255:0] req;
  logic [255:0] mapped;
  logic valid;
  logic ready;
  logic [23:0] xaddr;
  logic [23:0] last;
  int taken;
  int errors = 0;
  int checked = 0;
  always #50 clk = ~clk;
  dma_channel_trigger uut (.core_clk_in(clk), .resetn_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata),
    .periph_req_in(req), .periph_mapped_in(mapped), .xfer_valid_out(valid),
    .xfer_addr_out(xaddr), .xfer_ready_in(ready));
  dma_far_model far (.core_clk_in(clk), .resetn_in(rst_n), .stall_in(stall),
    .fire_code_in(code), .fire_in(fire), .xfer_valid_in(valid), .xfer_addr_in(xaddr),
    .periph_req_out(req), .periph_mapped_out(mapped), .xfer_ready_out(ready),
    .last_addr_out(last), .taken_out(taken));
  // ----
  // helpers
  // ----
  task automatic finish_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    rd_s <= 1'b0;
  endtask : wr
  task automatic idle(input int n);
    @(posedge clk);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    wr_s <= 1'b0;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd
  task automatic wait_taken(input int n);
    for (int i = 0; i < 60 && taken < n; i++)
      @(posedge clk);
    if (taken < n)
    begin
      errors++;
      finish_test();
    end
  endtask : wait_taken
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rd(reg_start_addr_high_off, 16'h0000);
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0000);
    wr(reg_start_addr_high_off, 16'habcd);
    rd(reg_start_addr_high_off, 16'h00cd);
    wr(reg_start_addr_low_off, 16'h1234);
    rd(reg_start_addr_low_off, 16'h1234);
  endtask : t_regs
  task automatic t_manual();
    int n;
    wr(reg_channel_ctrl_off, 16'h0001);
    stall <= 1'b1;
    wr(reg_request_select_off, 16'h8000);
    wr(reg_request_select_off, 16'h0000);
    rd(reg_request_select_off, 16'h8000);
    idle(6);
    rd(reg_request_select_off, 16'h0000);
    chk({23'h00_0000, valid}, 24'h00_0001);
    chk(xaddr, 24'hcd_1234);
    // output register and both buffer entries fill, so the fourth trigger stays pending
    repeat (3)
    begin
      wr(reg_request_select_off, 16'h8000);
      idle(8);
    end
    rd(reg_request_select_off, 16'h8000);
    wr(reg_channel_ctrl_off, 16'h0000);
    idle(1);
    rd(reg_request_select_off, 16'h0000);
    // a set while the channel is off is dropped
    wr(reg_request_select_off, 16'h8000);
    rd(reg_request_select_off, 16'h0000);
    // the four words already launched still drain; nothing new may start
    n = taken + 4;
    @(posedge clk);
    stall <= 1'b0;
    wait_taken(n);
    idle(10);
    chk(24'(taken), 24'(n));
  endtask : t_manual
  task automatic t_select();
    logic [7:0] codes [3] = '{8'h00, 8'h0a, 8'h5b};
    int n;
    wr(reg_channel_ctrl_off, 16'h0001);
    wr(reg_request_select_off, 16'h005c);
    code <= 8'h5c;
    fire <= 1'b1;
    n = taken;
    idle(12);
    fire <= 1'b0;
    chk(24'(taken), 24'(n));
    foreach (codes[i])
    begin
      wr(reg_request_select_off, {8'h00, codes[i]});
      code <= codes[i];
      fire <= 1'b1;
      idle(0);
      wait_taken(taken + 1);
      fire <= 1'b0;
      idle(12);
    end
    chk(last, 24'hcd_1234);
  endtask : t_select
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_manual();
    t_select();
    finish_test();
  end
endmodule : test_dma_channel_trigger
